// ==== src/vliw_pkg.sv ====
// Shared constants and types of the VLIW fetch and dispatch block
package vliw_pkg;
	localparam int SLOTS = 8;
	localparam int IW = 32;
	localparam int FETCH_W = 256;
	localparam int NREG = 32;
	localparam int RA = 5;
	localparam int UNITS = 8;
	localparam int UPS = 4;
	localparam int SIDES = 2;
	localparam int NCREG = 8;
	localparam int CHAIN_BIT = 0;
	localparam int UNIT_LSB = 1;
	localparam int UNIT_MSB = 3;
	localparam int XP_BIT = 4;
	localparam int SRC_LSB = 5;
	localparam int SRC_MSB = 9;
	localparam int Z_BIT = 28;
	localparam int CREG_LSB = 29;
	localparam int CREG_MSB = 31;
	localparam logic [2:0] CREG_ALWAYS = 3'h0;
	localparam int OFS_SHORT = 5;
	localparam int OFS_LONG = 15;
	typedef enum logic [1:0] {
		FS_REQ = 2'b00,
		FS_WAIT = 2'b01,
		FS_RUN = 2'b10
	} fetch_state_t;
	typedef enum logic [1:0] {
		SZ_BYTE = 2'b00,
		SZ_HALF = 2'b01,
		SZ_WORD = 2'b10,
		SZ_DWORD = 2'b11
	} ls_size_t;
	typedef enum logic [2:0] {
		OP_ADD32 = 3'b000,
		OP_ADD16 = 3'b001,
		OP_ADD8 = 3'b010,
		OP_MUL16 = 3'b011,
		OP_MUL8 = 3'b100
	} lane_op_t;
	typedef struct packed {
		logic en;
		logic [RA-1:0] addr;
		logic [IW-1:0] data;
	} wb_t;
	typedef struct packed {
		logic valid;
		ls_size_t size;
		logic nonaligned;
		logic circ;
		logic long_ofs;
		logic [OFS_LONG-1:0] ofs;
		logic [RA-1:0] blk;
		logic [IW-1:0] base;
		logic dst_side;
	} ls_req_t;
	typedef struct packed {
		logic valid;
		logic [IW-1:0] addr;
		logic misaligned;
		ls_size_t size;
		logic dst_side;
	} ls_out_t;
	typedef struct packed {
		lane_op_t op;
		logic [IW-1:0] a;
		logic [IW-1:0] b;
	} ex_req_t;
	typedef struct packed {
		logic [IW-1:0] hi;
		logic [IW-1:0] lo;
	} ex_res_t;
endpackage

// ==== src/side_regfile.sv ====
// One side's register file: local read ports and a cross-side read port
`timescale 1ns/100ps
`default_nettype none
module side_regfile #(
	parameter int NP = vliw_pkg::UPS
)(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire vliw_pkg::wb_t i_wb,
	input wire logic [NP-1:0][vliw_pkg::RA-1:0] i_rd_addr,
	output logic [NP-1:0][vliw_pkg::IW-1:0] o_rd_data,
	input wire logic [vliw_pkg::RA-1:0] i_x_addr,
	output logic [vliw_pkg::IW-1:0] o_x_data,
	output logic [vliw_pkg::NREG-1:0] o_recent
);
	logic [vliw_pkg::IW-1:0] mem [vliw_pkg::NREG];
	logic [vliw_pkg::RA-1:0] x_addr_r;

	if (NP < 1)
		$error("side_regfile needs at least one read port");

	always_ff @(posedge i_clock)
	begin
		if (i_wb.en)
			mem[i_wb.addr] <= i_wb.data;
	end

	// Same-side reads all served in the same cycle
	for (genvar p = 0; p < NP; p++)
	begin : g_rd
		assign o_rd_data[p] = mem[i_rd_addr[p]];
	end

	// Cross-side read is staged through an address register
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			x_addr_r <= 5'h00;
		else
			x_addr_r <= i_x_addr;
	end
	assign o_x_data = mem[x_addr_r];

	// Marks the register written in the previous cycle
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			o_recent <= 32'h0000_0000;
		else if (i_wb.en)
			o_recent <= 32'h0000_0001 << i_wb.addr;
		else
			o_recent <= 32'h0000_0000;
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	property p_recent;
		i_wb.en |=> o_recent[$past(i_wb.addr)] && $onehot(o_recent);
	endproperty
	a_recent: assert property (p_recent) else $error("recent mark lost");

	property p_local_read;
		i_wb.en ##1 (!i_wb.en && i_rd_addr[0] == $past(i_wb.addr))
			|-> o_rd_data[0] == $past(i_wb.data);
	endproperty
	a_local_read: assert property (p_local_read) else $error("bad read");
endmodule // side_regfile
`default_nettype wire

// ==== src/lane_unit.sv ====
// Packed arithmetic and multiply lanes with wide and normal results
`timescale 1ns/100ps
`default_nettype none
module lane_unit (
	input wire vliw_pkg::ex_req_t i_req,
	output vliw_pkg::ex_res_t o_res
);
	logic [3:0][7:0] sum8;
	logic [3:0][15:0] prod8;
	logic [1:0][15:0] sum16;
	logic [1:0][31:0] prod16;

	for (genvar i = 0; i < 4; i++)
	begin : g_b
		assign sum8[i] = i_req.a[8*i+:8] + i_req.b[8*i+:8];
		assign prod8[i] = i_req.a[8*i+:8] * i_req.b[8*i+:8];
	end
	for (genvar i = 0; i < 2; i++)
	begin : g_h
		assign sum16[i] = i_req.a[16*i+:16] + i_req.b[16*i+:16];
		assign prod16[i] = i_req.a[16*i+:16] * i_req.b[16*i+:16];
	end

	always_comb
	begin
		o_res = '0;
		case (i_req.op)
			vliw_pkg::OP_ADD32: o_res.lo = i_req.a + i_req.b;
			vliw_pkg::OP_ADD16: o_res.lo = sum16;
			vliw_pkg::OP_ADD8: o_res.lo = sum8;
			vliw_pkg::OP_MUL16:
			begin
				o_res.hi = prod16[1];
				o_res.lo = prod16[0];
			end
			vliw_pkg::OP_MUL8:
			begin
				o_res.hi = {prod8[3], prod8[2]};
				o_res.lo = {prod8[1], prod8[0]};
			end
			default: o_res = '0;
		endcase
	end
endmodule // lane_unit
`default_nettype wire

// ==== src/vliw_packet_dispatch.sv ====
// Fetch packet splitting and execute packet dispatch for the VLIW core
`timescale 1ns/100ps
`default_nettype none
module vliw_packet_dispatch #(
	parameter int SLOT_N = vliw_pkg::SLOTS
)(
	input wire logic i_clock,
	input wire logic i_rst,
	output logic o_fetch_req,
	input wire logic i_fetch_valid,
	input wire logic [vliw_pkg::FETCH_W-1:0] i_fetch_data,
	output logic [vliw_pkg::UNITS-1:0] o_issue_valid,
	output logic [vliw_pkg::UNITS-1:0] o_issue_exec,
	output logic [vliw_pkg::UNITS-1:0][vliw_pkg::IW-1:0] o_issue_instr,
	output logic [vliw_pkg::UNITS-1:0][vliw_pkg::IW-1:0] o_src,
	output logic [vliw_pkg::SIDES-1:0][vliw_pkg::IW-1:0] o_xpath_data,
	output logic o_stall,
	output logic o_conflict,
	input wire logic [vliw_pkg::NCREG-1:0] i_cond_nz,
	input wire vliw_pkg::wb_t [vliw_pkg::SIDES-1:0] i_wb,
	input wire vliw_pkg::ls_req_t [vliw_pkg::SIDES-1:0] i_ls,
	output vliw_pkg::ls_out_t [vliw_pkg::SIDES-1:0] o_ls,
	input wire vliw_pkg::ex_req_t [vliw_pkg::SIDES-1:0] i_ex,
	output vliw_pkg::ex_res_t [vliw_pkg::SIDES-1:0] o_ex
);
	localparam int PW = $clog2(SLOT_N + 1);
	localparam int NC = 2 * SLOT_N;
	localparam int IW = vliw_pkg::IW;
	localparam int UN = vliw_pkg::UNITS;
	localparam int SD = vliw_pkg::SIDES;
	localparam int UPS = vliw_pkg::UPS;
	localparam int RA = vliw_pkg::RA;

	if (SLOT_N * IW != vliw_pkg::FETCH_W)
		$error("SLOT_N must fill the fetch packet exactly");

	vliw_pkg::fetch_state_t state_r;
	logic fetch_req_r;
	logic [IW-1:0] buf_r [SLOT_N];
	logic [IW-1:0] car_r [SLOT_N];
	logic [PW-1:0] pos_r;
	logic [PW-1:0] ccnt_r;
	logic stall_r;
	logic take_fetch;
	logic [SLOT_N-1:0] take;
	logic end_found;
	logic [PW-1:0] ntake;
	logic [PW:0] pkt_cnt;
	logic carry;
	logic go;
	logic stall_now;
	logic drain;
	logic [PW-1:0] pos_nxt;
	logic [NC-1:0] cand_v;
	logic [IW-1:0] cand_i [NC];
	logic [UN-1:0] hit;
	logic [IW-1:0] uins [UN];
	logic conf;
	logic xhit;
	logic [SD-1:0] xuse;
	logic [SD-1:0][RA-1:0] xreg;
	logic [UN-1:0] cmask;
	logic [SD-1:0][vliw_pkg::NREG-1:0] recent;
	logic [SD-1:0][UPS-1:0][RA-1:0] rd_addr;
	logic [SD-1:0][UPS-1:0][IW-1:0] rd_data;
	logic [SD-1:0][IW-1:0] x_data;
	vliw_pkg::ex_res_t [SD-1:0] ex_res;

	assign o_fetch_req = fetch_req_r;

	// ----------------------------------------------------------------
	// Fetch sequencing
	// ----------------------------------------------------------------
	assign take_fetch = state_r == vliw_pkg::FS_WAIT && i_fetch_valid;
	assign drain = state_r == vliw_pkg::FS_RUN && pos_nxt == PW'(SLOT_N);

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			state_r <= vliw_pkg::FS_REQ;
			fetch_req_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				vliw_pkg::FS_REQ:
				begin
					state_r <= vliw_pkg::FS_WAIT;
					fetch_req_r <= 1'b1;
				end
				vliw_pkg::FS_WAIT:
				if (i_fetch_valid)
				begin
					state_r <= vliw_pkg::FS_RUN;
					fetch_req_r <= 1'b0;
				end
				vliw_pkg::FS_RUN:
				if (drain)
				begin
					state_r <= vliw_pkg::FS_WAIT;
					fetch_req_r <= 1'b1;
				end
				default:
				begin
					state_r <= vliw_pkg::FS_REQ;
					fetch_req_r <= 1'b0;
				end
			endcase
		end
	end

	// Eight 32-bit slots, lowest slot first
	always_ff @(posedge i_clock)
	begin
		if (take_fetch)
		begin
			for (int i = 0; i < SLOT_N; i++)
				buf_r[i] <= i_fetch_data[IW*i+:IW];
		end
	end

	// ----------------------------------------------------------------
	// Execute packet boundary search
	// ----------------------------------------------------------------
	always_comb
	begin
		take = '0;
		end_found = 1'b0;
		ntake = '0;
		for (int i = 0; i < SLOT_N; i++)
		begin
			take[i] = state_r == vliw_pkg::FS_RUN && i >= int'(pos_r)
				&& !end_found;
			if (take[i])
				ntake = ntake + PW'(1);
			if (take[i] && !buf_r[i][vliw_pkg::CHAIN_BIT])
				end_found = 1'b1;
		end
	end

	assign pkt_cnt = (PW+1)'(ccnt_r) + (PW+1)'(ntake);
	assign carry = state_r == vliw_pkg::FS_RUN && !end_found
		&& pos_r < PW'(SLOT_N);
	assign stall_now = end_found && xhit && !stall_r;
	assign go = end_found && !stall_now;
	assign pos_nxt = go ? pos_r + ntake : carry ? PW'(SLOT_N) : pos_r;

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			pos_r <= PW'(SLOT_N);
		else if (take_fetch)
			pos_r <= '0;
		else
			pos_r <= pos_nxt;
	end

	// Unfinished tail waits here for the next fetch packet
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			ccnt_r <= '0;
		else if (go)
			ccnt_r <= '0;
		else if (carry)
			ccnt_r <= ccnt_r + ntake;
	end

	always_ff @(posedge i_clock)
	begin
		for (int j = 0; j < SLOT_N; j++)
		begin
			if (carry && take[j]
				&& int'(ccnt_r) + j - int'(pos_r) < SLOT_N)
				car_r[int'(ccnt_r) + j - int'(pos_r)] <= buf_r[j];
		end
	end

	// ----------------------------------------------------------------
	// Unit routing, cross-bus and condition checks
	// ----------------------------------------------------------------
	always_comb
	begin
		for (int k = 0; k < SLOT_N; k++)
		begin
			cand_v[k] = k < int'(ccnt_r) && end_found;
			cand_i[k] = car_r[k];
			cand_v[SLOT_N+k] = take[k] && end_found;
			cand_i[SLOT_N+k] = buf_r[k];
		end
	end

	always_comb
	begin
		int u;
		int s;
		logic [RA-1:0] r;
		u = 0;
		s = 0;
		r = '0;
		hit = '0;
		conf = 1'b0;
		xhit = 1'b0;
		xuse = '0;
		xreg = '0;
		for (int n = 0; n < UN; n++)
			uins[n] = '0;
		for (int k = 0; k < NC; k++)
		begin
			if (cand_v[k])
			begin
				u = int'(cand_i[k][vliw_pkg::UNIT_MSB:vliw_pkg::UNIT_LSB]);
				s = u / UPS;
				r = cand_i[k][vliw_pkg::SRC_MSB:vliw_pkg::SRC_LSB];
				if (hit[u])
					conf = 1'b1;
				hit[u] = 1'b1;
				uins[u] = cand_i[k];
				if (cand_i[k][vliw_pkg::XP_BIT])
				begin
					if (xuse[s] && xreg[s] != r)
						conf = 1'b1;
					xuse[s] = 1'b1;
					xreg[s] = r;
					if (recent[SD-1-s][r])
						xhit = 1'b1;
				end
			end
		end
		if (pkt_cnt > (PW+1)'(SLOT_N))
			conf = 1'b1;
	end

	always_comb
	begin
		logic [2:0] cr;
		cr = '0;
		for (int n = 0; n < UN; n++)
		begin
			cr = uins[n][vliw_pkg::CREG_MSB:vliw_pkg::CREG_LSB];
			cmask[n] = cr == vliw_pkg::CREG_ALWAYS
				|| (i_cond_nz[cr] ^ uins[n][vliw_pkg::Z_BIT]);
		end
	end

	// ----------------------------------------------------------------
	// Register files and packed execution lanes, one per side
	// ----------------------------------------------------------------
	for (genvar s = 0; s < SD; s++)
	begin : g_side
		for (genvar p = 0; p < UPS; p++)
		begin : g_port
			assign rd_addr[s][p] =
				uins[s*UPS+p][vliw_pkg::SRC_MSB:vliw_pkg::SRC_LSB];
		end
		side_regfile #(.NP(UPS)) u_rf (
			.i_clock(i_clock),
			.i_rst(i_rst),
			.i_wb(i_wb[s]),
			.i_rd_addr(rd_addr[s]),
			.o_rd_data(rd_data[s]),
			.i_x_addr(xreg[SD-1-s]),
			.o_x_data(x_data[s]),
			.o_recent(recent[s])
		);
		lane_unit u_lane (
			.i_req(i_ex[s]),
			.o_res(ex_res[s])
		);
		always_ff @(posedge i_clock)
		begin
			if (i_rst)
			begin
				o_xpath_data[s] <= 32'h0000_0000;
				o_ex[s] <= '0;
			end
			else
			begin
				o_xpath_data[s] <= x_data[SD-1-s];
				o_ex[s] <= ex_res[s];
			end
		end

		// Address generation: scaled offset, linear or circular
		logic [IW-1:0] ofs;
		logic [IW-1:0] sum;
		logic [IW-1:0] mask;
		logic [IW-1:0] addr;
		logic [IW-1:0] amask;
		assign ofs = i_ls[s].long_ofs
			? IW'(i_ls[s].ofs)
			: IW'(i_ls[s].ofs[vliw_pkg::OFS_SHORT-1:0]);
		assign sum = i_ls[s].base + (ofs << i_ls[s].size);
		assign mask = (32'h0000_0002 << i_ls[s].blk) - 32'h0000_0001;
		assign addr = i_ls[s].circ
			? (i_ls[s].base & ~mask) | (sum & mask) : sum;
		assign amask = (32'h0000_0001 << i_ls[s].size) - 32'h0000_0001;
		always_ff @(posedge i_clock)
		begin
			if (i_rst)
				o_ls[s] <= '0;
			else
			begin
				o_ls[s].valid <= i_ls[s].valid;
				o_ls[s].addr <= addr;
				o_ls[s].size <= i_ls[s].size;
				o_ls[s].dst_side <= i_ls[s].dst_side;
				o_ls[s].misaligned <= i_ls[s].valid && |(addr & amask)
					&& !(i_ls[s].nonaligned
					&& i_ls[s].size >= vliw_pkg::SZ_WORD);
			end
		end
	end

	// ----------------------------------------------------------------
	// Issue stage
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			stall_r <= 1'b0;
		else
			stall_r <= stall_now;
	end
	assign o_stall = stall_r;

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			o_issue_valid <= 8'h00;
			o_issue_exec <= 8'h00;
			o_conflict <= 1'b0;
		end
		else
		begin
			o_issue_valid <= go ? hit : 8'h00;
			o_issue_exec <= go ? hit & cmask : 8'h00;
			o_conflict <= go && conf;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			for (int n = 0; n < UN; n++)
			begin
				o_issue_instr[n] <= 32'h0000_0000;
				o_src[n] <= 32'h0000_0000;
			end
		end
		else if (go)
		begin
			for (int n = 0; n < UN; n++)
			begin
				o_issue_instr[n] <= uins[n];
				o_src[n] <= rd_data[n/UPS][n%UPS];
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	property p_fetch_drained;
		o_fetch_req |-> pos_r == PW'(SLOT_N)
			&& state_r == vliw_pkg::FS_WAIT;
	endproperty
	a_fetch_drained: assert property (p_fetch_drained)
		else $error("fetch before drain");

	property p_load_slots;
		take_fetch |=> pos_r == '0 && buf_r[1] == $past(i_fetch_data[63:32]);
	endproperty
	a_load_slots: assert property (p_load_slots)
		else $error("fetch packet not split into slots");

	property p_packet_size;
		go && !conf |=> $countones(o_issue_valid) == $past(pkt_cnt);
	endproperty
	a_packet_size: assert property (p_packet_size)
		else $error("issued count differs from chain length");

	property p_break;
		go |=> ccnt_r == '0 && pos_r == $past(pos_r) + $past(ntake);
	endproperty
	a_break: assert property (p_break)
		else $error("packet end not honoured");

	property p_span;
		carry |=> ccnt_r == $past(ccnt_r) + $past(ntake) ##1 o_fetch_req;
	endproperty
	a_span: assert property (p_span)
		else $error("spanning tail not carried");

	sequence s_stall;
		stall_now ##1 (o_stall && o_issue_valid == 8'h00);
	endsequence
	property p_stall_one;
		s_stall |-> go ##1 o_issue_valid != 8'h00;
	endproperty
	a_stall_one: assert property (p_stall_one)
		else $error("cross stall not exactly one cycle");

	property p_hold_packet;
		stall_now |=> $stable(pos_r) && $stable(ccnt_r);
	endproperty
	a_hold_packet: assert property (p_hold_packet)
		else $error("packet split by stall");

	property p_wide_mul;
		i_ex[0].op == vliw_pkg::OP_MUL16 |=> o_ex[0].hi
			== $past(i_ex[0].a[31:16]) * $past(i_ex[0].b[31:16]);
	endproperty
	a_wide_mul: assert property (p_wide_mul)
		else $error("upper product not on wide port");

	property p_nonaligned;
		i_ls[0].valid && i_ls[0].nonaligned
			&& i_ls[0].size == vliw_pkg::SZ_DWORD |=> !o_ls[0].misaligned;
	endproperty
	a_nonaligned: assert property (p_nonaligned)
		else $error("non-aligned access refused");
endmodule // vliw_packet_dispatch
`default_nettype wire

// ==== bench/prog_mem_model.sv ====
// Program memory model that answers fetch requests of the dispatcher
`timescale 1ns/100ps
`default_nettype none
module prog_mem_model (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_fetch_req,
	input wire logic i_hold,
	input wire logic i_slow,
	input wire logic [vliw_pkg::FETCH_W-1:0] i_next_pkt,
	output logic o_fetch_valid,
	output logic [vliw_pkg::FETCH_W-1:0] o_fetch_data
);
	logic [1:0] wait_r;
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			o_fetch_valid <= 1'b0;
			o_fetch_data <= {vliw_pkg::FETCH_W{1'b1}};
			wait_r <= 2'h0;
		end
		else if (o_fetch_valid && i_fetch_req)
		begin
			// Taken: the bus stops showing the packet at once
			o_fetch_valid <= 1'b0;
			o_fetch_data <= ~o_fetch_data;
			wait_r <= 2'h0;
		end
		else if (!o_fetch_valid && i_fetch_req && !i_hold &&
			(!i_slow || wait_r == 2'h3))
		begin
			o_fetch_valid <= 1'b1;
			o_fetch_data <= i_next_pkt;
		end
		else if (!o_fetch_valid)
		begin
			// Idle bus toggles so stale data never looks valid
			o_fetch_data <= ~o_fetch_data;
			if (i_fetch_req && !i_hold)
				wait_r <= wait_r + 2'h1;
		end
	end
endmodule // prog_mem_model
`default_nettype wire

// ==== bench/vliw_packet_dispatch_tb_top.sv ====
// Self-checking testbench of the VLIW fetch and dispatch block
`timescale 1ns/100ps
`default_nettype none
module vliw_packet_dispatch_tb_top;
	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	logic hold = 1'b1;
	logic slow = 1'b0;
	logic [vliw_pkg::FETCH_W-1:0] next_pkt = '0;
	logic o_fetch_req;
	logic fetch_valid;
	logic [vliw_pkg::FETCH_W-1:0] fetch_data;
	logic [7:0] o_issue_valid;
	logic [7:0] o_issue_exec;
	logic [7:0][31:0] o_issue_instr;
	logic [7:0][31:0] o_src;
	logic [1:0][31:0] o_xpath_data;
	logic o_stall;
	logic o_conflict;
	logic [7:0] i_cond_nz = 8'h02;
	vliw_pkg::wb_t [1:0] i_wb = '0;
	vliw_pkg::ls_req_t [1:0] i_ls = '0;
	vliw_pkg::ls_out_t [1:0] o_ls;
	vliw_pkg::ex_req_t [1:0] i_ex = '0;
	vliw_pkg::ex_res_t [1:0] o_ex;
	int n_fail = 0;
	int num_checks = 0;
	logic saw_stall = 1'b0;
	logic [31:0] slot [8];

	always #2.5 i_clock = ~i_clock;

	vliw_packet_dispatch #(.SLOT_N(vliw_pkg::SLOTS)) vliw_packet_dispatch_inst (
		.i_clock(i_clock), .i_rst(i_rst), .o_fetch_req(o_fetch_req),
		.i_fetch_valid(fetch_valid), .i_fetch_data(fetch_data),
		.o_issue_valid(o_issue_valid), .o_issue_exec(o_issue_exec),
		.o_issue_instr(o_issue_instr), .o_src(o_src),
		.o_xpath_data(o_xpath_data), .o_stall(o_stall),
		.o_conflict(o_conflict), .i_cond_nz(i_cond_nz), .i_wb(i_wb),
		.i_ls(i_ls), .o_ls(o_ls), .i_ex(i_ex), .o_ex(o_ex));

	prog_mem_model prog_mem_model_inst (
		.i_clock(i_clock), .i_rst(i_rst), .i_fetch_req(o_fetch_req),
		.i_hold(hold), .i_slow(slow), .i_next_pkt(next_pkt),
		.o_fetch_valid(fetch_valid), .o_fetch_data(fetch_data));

	// ------------------------------------------------------------
	// Shared helpers
	// ------------------------------------------------------------
	task automatic check(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1)
		begin
			n_fail++;
			$display("MISMATCH t=%0t %s", $time, msg);
		end
	endtask

	function automatic logic [31:0] ins(input int u, input logic ch,
		input logic xp, input int src, input int cr, input logic z);
		ins = {cr[2:0], z, 18'h0, src[4:0], xp, u[2:0], ch};
	endfunction

	task automatic fetch();
		int k;
		next_pkt <= {slot[7], slot[6], slot[5], slot[4],
			slot[3], slot[2], slot[1], slot[0]};
		hold <= 1'b0;
		for (k = 0; k < 40; k++)
		begin
			@(posedge i_clock);
			#1;
			if (o_fetch_req === 1'b1 && fetch_valid === 1'b1)
				break;
		end
		@(posedge i_clock);
		hold <= 1'b1;
		check(k < 40, "fetch not taken");
	endtask

	task automatic wait_issue();
		saw_stall = 1'b0;
		for (int k = 0; k < 40; k++)
		begin
			@(posedge i_clock);
			#1;
			if (o_stall === 1'b1)
				saw_stall = 1'b1;
			if (o_issue_valid !== 8'h00)
				break;
		end
	endtask

	task automatic drain();
		for (int k = 0; k < 40 && o_fetch_req !== 1'b1; k++)
		begin
			@(posedge i_clock);
			#1;
		end
	endtask

	// Entries are {exec mask, valid mask}, one per clock, back to back
	task automatic exp_run(input logic [15:0] e[$]);
		wait_issue();
		foreach (e[i])
		begin
			if (i > 0)
			begin
				@(posedge i_clock);
				#1;
			end
			check(o_issue_valid === e[i][7:0], "issue mask");
			check(o_issue_exec === e[i][15:8], "exec mask");
			for (int u = 0; u < 8; u++)
				if (e[i][u])
					check(o_issue_instr[u][3:1] === 3'(u), "routing");
			if (i < e.size() - 1)
				check(o_fetch_req === 1'b0, "early fetch");
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_split();
		@(posedge i_clock);
		i_wb[0] <= {1'b1, 5'h03, 32'h5A5A_1234};
		@(posedge i_clock);
		i_wb[0] <= '0;
		slow <= 1'b1;
		slot = '{ins(0, 0, 0, 0, 0, 0), ins(1, 1, 0, 3, 1, 0),
			ins(4, 0, 0, 0, 2, 0), ins(0, 1, 0, 0, 2, 1),
			ins(2, 1, 0, 0, 0, 0), ins(5, 0, 0, 0, 0, 0),
			ins(3, 1, 0, 0, 0, 0), ins(7, 0, 0, 0, 0, 0)};
		fetch();
		exp_run({16'h0101, 16'h0212});
		check(o_src[1] === 32'h5A5A_1234, "same-side operand");
		check(o_fetch_req === 1'b0, "early fetch");
		exp_run({16'h2525, 16'h8888});
		check(saw_stall === 1'b0, "needless stall");
		slow <= 1'b0;
	endtask

	task automatic t_counts();
		logic [15:0] q[$];
		for (int i = 0; i < 8; i++)
		begin
			slot[i] = ins(i, 0, 0, 0, 0, 0);
			q.push_back({2{8'h01 << i}});
		end
		fetch();
		exp_run(q);
		for (int i = 0; i < 8; i++)
			slot[i] = ins(i, i < 7, 0, 0, 0, 0);
		fetch();
		exp_run({16'hFFFF});
		@(posedge i_clock);
		#1;
		check(o_issue_valid === 8'h00, "issue not one cycle");
	endtask

	task automatic t_conflict();
		slot[0] = ins(2, 1, 0, 0, 0, 0);
		slot[1] = ins(2, 0, 0, 0, 0, 0);
		for (int i = 2; i < 8; i++)
			slot[i] = ins(0, 0, 0, 0, 0, 0);
		fetch();
		wait_issue();
		check(o_conflict === 1'b1, "duplicate unit unflagged");
		drain();
	endtask

	task automatic t_span();
		logic [15:0] q[$];
		for (int i = 0; i < 8; i++)
			slot[i] = ins(i, i > 5, 0, 0, 0, 0);
		for (int i = 0; i < 6; i++)
			q.push_back({2{8'h01 << i}});
		fetch();
		exp_run(q);
		q = {16'hC3C3};
		for (int i = 0; i < 8; i++)
			slot[i] = ins(i, i == 0, 0, 0, 0, 0);
		for (int i = 2; i < 8; i++)
			q.push_back({2{8'h01 << i}});
		fetch();
		exp_run(q);
	endtask

	task automatic t_stall();
		slot[0] = ins(0, 1, 1, 5, 0, 0);
		slot[1] = ins(2, 0, 1, 5, 0, 0);
		for (int i = 2; i < 8; i++)
			slot[i] = ins(3, 0, 0, 0, 0, 0);
		slot[2] = ins(4, 0, 1, 3, 0, 0);
		i_wb[1] <= {1'b1, 5'h05, 32'hC0DE_0042};
		fetch();
		i_wb[1] <= '0;
		wait_issue();
		check(saw_stall === 1'b1, "no cross-path bubble");
		check(o_issue_valid === 8'h05, "held packet split");
		@(posedge i_clock);
		#1;
		check(o_xpath_data[0] === 32'hC0DE_0042, "cross operand");
		check(o_issue_valid === 8'h10, "side B packet");
		@(posedge i_clock);
		#1;
		check(o_xpath_data[1] === 32'h5A5A_1234, "cross operand B");
		drain();
	endtask

	task automatic ls_chk(input vliw_pkg::ls_req_t r, input logic [31:0] a,
		input logic mis);
		@(posedge i_clock);
		i_ls <= {r, r};
		@(posedge i_clock);
		#1;
		for (int s = 0; s < 2; s++)
		begin
			check(o_ls[s].valid === 1'b1 && o_ls[s].addr === a,
				"ls address");
			check(o_ls[s].misaligned === mis && o_ls[s].size === r.size &&
				o_ls[s].dst_side === r.dst_side, "ls flags");
		end
	endtask

	task automatic t_ls();
		logic [31:0] a;
		for (int s = 0; s < 4; s++)
		begin
			a = 32'h1000_0001 + (32'h3 << s);
			ls_chk({1'b1, 2'(s), 3'b001, 15'h0003, 5'h00, 32'h1000_0001,
				s[0]}, a, (a & ((32'h1 << s) - 1)) != 0);
		end
		ls_chk({1'b1, vliw_pkg::SZ_WORD, 3'b101, 15'h0003, 5'h00,
			32'h1000_0001, 1'b1}, 32'h1000_000D, 1'b0);
		ls_chk({1'b1, vliw_pkg::SZ_DWORD, 3'b101, 15'h0003, 5'h00,
			32'h1000_0001, 1'b0}, 32'h1000_0019, 1'b0);
		ls_chk({1'b1, vliw_pkg::SZ_BYTE, 3'b000, 15'h0043, 5'h00,
			32'h1000_0001, 1'b0}, 32'h1000_0004, 1'b0);
		ls_chk({1'b1, vliw_pkg::SZ_WORD, 3'b011, 15'h0002, 5'h03,
			32'h0000_100C, 1'b1}, 32'h0000_1004, 1'b0);
	endtask

	task automatic ex_chk(input vliw_pkg::lane_op_t op,
		input logic [31:0] a, b, lo, hi, input logic wide);
		@(posedge i_clock);
		i_ex <= {2{op, a, b}};
		@(posedge i_clock);
		#1;
		for (int s = 0; s < 2; s++)
		begin
			check(o_ex[s].lo === lo, "normal result");
			if (wide)
				check(o_ex[s].hi === hi, "wide result");
		end
	endtask

	task automatic t_ex();
		ex_chk(vliw_pkg::OP_ADD32, 32'h0102_FFFF, 32'h0304_0001,
			32'h0407_0000, 32'h0, 1'b0);
		ex_chk(vliw_pkg::OP_ADD16, 32'h0102_FFFF, 32'h0304_0001,
			32'h0406_0000, 32'h0, 1'b0);
		ex_chk(vliw_pkg::OP_ADD8, 32'h0102_FFFF, 32'h0304_0001,
			32'h0406_FF00, 32'h0, 1'b0);
		ex_chk(vliw_pkg::OP_MUL16, 32'h0102_0304, 32'h0506_0708,
			32'h0015_3420, 32'h0005_100C, 1'b1);
		ex_chk(vliw_pkg::OP_MUL8, 32'h0102_0304, 32'h0506_0708,
			32'h0015_0020, 32'h0005_000C, 1'b1);
	endtask

	// ------------------------------------------------------------
	// Run control
	// ------------------------------------------------------------
	task automatic give_verdict();
		if (n_fail == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (16) @(posedge i_clock);
		i_rst <= 1'b0;
		t_split();
		t_counts();
		t_conflict();
		t_span();
		t_stall();
		t_ls();
		t_ex();
		give_verdict();
	end

	// Whole run needs about a hundred cycles; this allows about 4000
	initial
	begin
		#20000;
		n_fail++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		give_verdict();
	end
endmodule // vliw_packet_dispatch_tb_top
`default_nettype wire
